// *** core/epml_pkg.sv ***
// Constants shared by the page metadata leaf unit: leaf codes, page types,
// register map, event bits, record layout and answer codes.
// Assumes 64-bit operands and a 32-bit register port with byte addresses.
package epml_pkg;
  // Leaf selector codes
  localparam logic [31:0] LEAF_VA_ADD = 32'h0000000a;
  localparam logic [31:0] LEAF_INFO_RD = 32'h00000010;
  // Page type encodings (arbitrary values)
  localparam logic [7:0] TYPE_CONTROL = 8'h00;
  localparam logic [7:0] TYPE_THREAD = 8'h01;
  localparam logic [7:0] TYPE_REGULAR = 8'h02;
  localparam logic [7:0] TYPE_VERSION_ARRAY = 8'h03;
  localparam logic [7:0] TYPE_TRIM = 8'h04;
  localparam logic [7:0] TYPE_SHADOW_FIRST = 8'h05;
  localparam logic [7:0] TYPE_SHADOW_REST = 8'h06;
  // Geometry
  localparam int PAGE_BYTES = 4096;
  localparam int WORD_BYTES = 8;
  localparam int PAGE_ALIGN_BITS = 12;
  localparam int REC_ALIGN_BITS = 5;
  localparam logic [63:0] WORD_STEP = 64'h0000000000000008;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam int CTRL_INFO_PRESENT = 0;
  localparam int CTRL_GUEST = 1;
  localparam int CTRL_VIRT_EXT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam int EV_DONE = 0;
  localparam int EV_GP = 1;
  localparam int EV_PF = 2;
  localparam int EV_EXIT = 3;
  // Answer kinds
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_GP = 2'h1;
  localparam logic [1:0] RES_PF = 2'h2;
  localparam logic [1:0] RES_EXIT = 2'h3;
  // Return codes (nonzero values arbitrary)
  localparam logic [63:0] RC_OK = 64'h0;
  localparam logic [63:0] RC_CONFLICT = 64'h7;
  localparam logic [63:0] RC_INVALID = 64'h8;
  localparam logic [63:0] RC_NON_CACHE = 64'h9;
  localparam logic [15:0] GP_ERROR_CODE = 16'h0000;
  localparam logic [15:0] EXIT_REASON_CONFLICT = 16'h0040;
  localparam logic [15:0] EXIT_QUAL_CONFLICT = 16'h0001;
  localparam logic [15:0] EXIT_ERROR = 16'h0000;
  // Info record layout: status word, flags word, context word
  localparam logic [63:0] STS_NON_CACHE = 64'h2;
  localparam logic [63:0] STS_INVALID = 64'h0;
  localparam logic [63:0] STS_VALID = 64'h1;
  localparam int FLG_RWX = 0;
  localparam int FLG_BLOCKED = 3;
  localparam int FLG_PENDING = 4;
  localparam int FLG_MODIFIED = 5;
  localparam int FLG_RESTRICT = 6;
  localparam int FLG_TYPE = 8;
  localparam logic [1:0] REC_ONE_WORD = 2'h0;
  localparam logic [1:0] REC_ALL_WORDS = 2'h2;
endpackage : epml_pkg

// *** core/epml_leaf_unit.sv ***
// Execution unit for the version-array add and page-info read leaves.
// Assumes metadata lookups answer on the same clock, a memory write port
// with ready back-pressure, and software steering through a small register port.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module epml_leaf_unit #(
  parameter int PAGE_WORDS = epml_pkg::PAGE_BYTES / epml_pkg::WORD_BYTES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [31:0] leaf_selector_register,
  input wire logic [63:0] first_operand_register,
  input wire logic [63:0] second_operand_register,
  output logic meta_req,
  output logic [63:0] meta_addr,
  input wire logic meta_ack,
  input wire logic meta_in_cache,
  input wire logic meta_conflict,
  input wire logic meta_valid,
  input wire logic [7:0] meta_type,
  input wire logic meta_blocked,
  input wire logic meta_pending,
  input wire logic meta_modified,
  input wire logic meta_restrict,
  input wire logic [2:0] meta_rwx,
  input wire logic [63:0] meta_phys,
  input wire logic [63:0] meta_context,
  output logic meta_wr,
  output logic [7:0] meta_wr_type,
  output logic [63:0] meta_wr_location,
  output logic [6:0] meta_wr_attr,
  output logic meta_wr_valid,
  output logic page_lock,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [63:0] mem_wr_addr,
  output logic [63:0] mem_wr_data,
  output logic done,
  output logic [1:0] result,
  output logic [63:0] fault_addr,
  output logic [15:0] err_code,
  output logic [63:0] ret_code,
  output logic flags_upd,
  output logic zf,
  output logic cf,
  output logic [15:0] exit_reason,
  output logic [15:0] exit_qual,
  output logic [15:0] exit_error,
  output logic [63:0] exit_gpa
);
  if (PAGE_WORDS < 2 || PAGE_WORDS > 1024) begin : g_bad_words
    $error("PAGE_WORDS must lie in 2..1024");
  end

  typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_ZERO, S_META, S_REC} epml_state_type;

  typedef struct packed {
    epml_state_type st;
    logic info;
    logic [63:0] base;
    logic [63:0] rec;
    logic [9:0] idx;
    logic [1:0] last;
    logic [63:0] waddr;
    logic [63:0] wdata;
    logic [2:0][63:0] wbuf;
    logic done;
    logic [1:0] res;
    logic [63:0] ret;
    logic fupd;
    logic zf;
    logic cf;
    logic [63:0] gpa;
    logic [2:0] ctrl;
    logic [3:0] sts;
    logic [3:0] ena;
    logic [31:0] rdata;
  } epml_regs_type;

  epml_regs_type s_q;
  epml_regs_type s_d;

  function automatic epml_regs_type finish(epml_regs_type s, logic [1:0] r);
    epml_regs_type t;
    t = s;
    t.st = S_IDLE;
    t.done = 1'b1;
    t.res = r;
    return t;
  endfunction : finish

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    logic [3:0] ev;
    logic [3:0] clr;
    logic [63:0] fl;
    logic child;
    ev = '0;
    clr = '0;
    fl = '0;
    child = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;
    if (reg_wr && reg_addr == epml_pkg::ADDR_CTRL) begin
      s_d.ctrl = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == epml_pkg::ADDR_ENABLE) begin
      s_d.ena = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == epml_pkg::ADDR_CLEAR) begin
      clr = reg_wdata[3:0];
    end
    case (s_q.st)
      S_IDLE: begin
        if (cmd_valid) begin
          s_d.base = second_operand_register;
          s_d.rec = first_operand_register;
          s_d.fupd = 1'b0;
          s_d.zf = 1'b0;
          s_d.cf = 1'b0;
          s_d.ret = epml_pkg::RC_OK;
          if (leaf_selector_register == epml_pkg::LEAF_VA_ADD) begin
            s_d.info = 1'b0;
            if (first_operand_register != 64'(epml_pkg::TYPE_VERSION_ARRAY) ||
                second_operand_register[epml_pkg::PAGE_ALIGN_BITS-1:0] != '0) begin
              s_d = finish(s_d, epml_pkg::RES_GP);
            end else begin
              s_d.st = S_REQ;
            end
          end else if (leaf_selector_register == epml_pkg::LEAF_INFO_RD &&
                       s_q.ctrl[epml_pkg::CTRL_INFO_PRESENT]) begin
            s_d.info = 1'b1;
            s_d.fupd = 1'b1;
            if (first_operand_register[epml_pkg::REC_ALIGN_BITS-1:0] != '0 ||
                second_operand_register[epml_pkg::PAGE_ALIGN_BITS-1:0] != '0) begin
              s_d.fupd = 1'b0;
              s_d = finish(s_d, epml_pkg::RES_GP);
            end else begin
              s_d.st = S_REQ;
            end
          end else begin
            // Unknown or absent leaf is refused like a bad operand
            s_d = finish(s_d, epml_pkg::RES_GP);
          end
        end
      end
      S_REQ: begin
        s_d.st = S_WAIT;
      end
      S_WAIT: begin
        if (meta_ack && !s_q.info) begin
          s_d.gpa = meta_phys;
          if (!meta_in_cache) begin
            s_d = finish(s_d, epml_pkg::RES_PF);
          end else if (meta_conflict) begin
            if (s_q.ctrl[epml_pkg::CTRL_GUEST] && s_q.ctrl[epml_pkg::CTRL_VIRT_EXT]) begin
              s_d = finish(s_d, epml_pkg::RES_EXIT);
            end else begin
              s_d = finish(s_d, epml_pkg::RES_GP);
            end
          end else if (meta_valid) begin
            s_d = finish(s_d, epml_pkg::RES_PF);
          end else begin
            s_d.st = S_ZERO;
            s_d.idx = '0;
            s_d.waddr = s_q.base;
            s_d.wdata = '0;
          end
        end else if (meta_ack) begin
          fl[epml_pkg::FLG_RWX +: 3] = meta_rwx;
          fl[epml_pkg::FLG_BLOCKED] = meta_blocked;
          fl[epml_pkg::FLG_PENDING] = meta_pending;
          fl[epml_pkg::FLG_MODIFIED] = meta_modified;
          fl[epml_pkg::FLG_RESTRICT] = meta_restrict;
          fl[epml_pkg::FLG_TYPE +: 8] = meta_type;
          child = meta_type inside {epml_pkg::TYPE_REGULAR, epml_pkg::TYPE_THREAD,
                                    epml_pkg::TYPE_TRIM, epml_pkg::TYPE_SHADOW_FIRST,
                                    epml_pkg::TYPE_SHADOW_REST, epml_pkg::TYPE_CONTROL};
          s_d.idx = '0;
          s_d.waddr = s_q.rec;
          s_d.st = S_REC;
          s_d.last = epml_pkg::REC_ONE_WORD;
          if (!meta_in_cache) begin
            s_d.wdata = epml_pkg::STS_NON_CACHE;
            s_d.ret = epml_pkg::RC_NON_CACHE;
            s_d.cf = 1'b1;
          end else if (meta_conflict) begin
            s_d.ret = epml_pkg::RC_CONFLICT;
            s_d.zf = 1'b1;
            s_d = finish(s_d, epml_pkg::RES_OK);
          end else if (!meta_valid) begin
            s_d.wdata = epml_pkg::STS_INVALID;
            s_d.ret = epml_pkg::RC_INVALID;
            s_d.cf = 1'b1;
          end else begin
            // valid status, then flags, then context
            s_d.wdata = epml_pkg::STS_VALID;
            s_d.wbuf[1] = fl;
            s_d.wbuf[2] = child ? meta_context : '0;
            s_d.last = epml_pkg::REC_ALL_WORDS;
          end
        end
      end
      S_ZERO: begin
        // stream zero words over the page
        if (mem_wr_ready) begin
          s_d.idx = s_q.idx + 10'h1;
          s_d.waddr = s_q.waddr + epml_pkg::WORD_STEP;
          if (s_q.idx == 10'(PAGE_WORDS - 1)) begin
            s_d.st = S_META;
          end
        end
      end
      S_META: begin
        s_d = finish(s_d, epml_pkg::RES_OK);
      end
      S_REC: begin
        if (mem_wr_ready) begin
          s_d.idx = s_q.idx + 10'h1;
          s_d.waddr = s_q.waddr + epml_pkg::WORD_STEP;
          // Last word: nothing beyond the context word may be indexed
          if (s_q.idx[1:0] == s_q.last) begin
            s_d.wdata = '0;
            s_d = finish(s_d, epml_pkg::RES_OK);
          end else begin
            s_d.wdata = s_q.wbuf[s_q.idx[1:0] + 2'h1];
          end
        end
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
    if (s_d.done) begin
      ev[epml_pkg::EV_DONE] = 1'b1;
      ev[epml_pkg::EV_GP] = s_d.res == epml_pkg::RES_GP;
      ev[epml_pkg::EV_PF] = s_d.res == epml_pkg::RES_PF;
      ev[epml_pkg::EV_EXIT] = s_d.res == epml_pkg::RES_EXIT;
    end
    // A new event wins over a clear in the same cycle
    s_d.sts = (s_q.sts & ~clr) | ev;
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        epml_pkg::ADDR_CTRL: s_d.rdata = 32'(s_q.ctrl);
        epml_pkg::ADDR_STATUS: s_d.rdata = 32'(s_q.sts);
        epml_pkg::ADDR_ENABLE: s_d.rdata = 32'(s_q.ena);
        epml_pkg::ADDR_RESULT: s_d.rdata = {24'h0, s_q.zf, s_q.cf, s_q.res, 1'b0, s_q.st};
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= epml_pkg::CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign irq = |(s_q.sts & s_q.ena);
  assign cmd_ready = s_q.st == S_IDLE;
  assign meta_req = s_q.st == S_REQ;
  assign meta_addr = s_q.base;
  // metadata entry for the new version array
  assign meta_wr = s_q.st == S_META;
  assign meta_wr_type = epml_pkg::TYPE_VERSION_ARRAY;
  assign meta_wr_location = '0;
  assign meta_wr_attr = '0;
  assign meta_wr_valid = 1'b1;
  // exclusive hold from lookup to metadata write
  assign page_lock = !s_q.info && s_q.st inside {S_REQ, S_WAIT, S_ZERO, S_META};
  assign mem_wr_valid = s_q.st inside {S_ZERO, S_REC};
  assign mem_wr_addr = s_q.waddr;
  assign mem_wr_data = s_q.wdata;
  assign done = s_q.done;
  assign result = s_q.res;
  assign fault_addr = s_q.base;
  assign err_code = epml_pkg::GP_ERROR_CODE;
  assign ret_code = s_q.ret;
  // flags only reported by the info read
  assign flags_upd = s_q.fupd;
  assign zf = s_q.zf;
  assign cf = s_q.cf;
  assign exit_reason = epml_pkg::EXIT_REASON_CONFLICT;
  assign exit_qual = epml_pkg::EXIT_QUAL_CONFLICT;
  assign exit_error = epml_pkg::EXIT_ERROR;
  assign exit_gpa = s_q.gpa;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic add_ack;
  assign add_ack = s_q.st == S_WAIT && meta_ack && !s_q.info;

  sequence last_zero_word;
    s_q.st == S_ZERO && mem_wr_ready && s_q.idx == 10'(PAGE_WORDS - 1);
  endsequence
  sequence meta_then_done;
    meta_wr ##1 (done && result == epml_pkg::RES_OK);
  endsequence

  chk_bad_type_gp: assert property (
    (cmd_ready && cmd_valid && leaf_selector_register == epml_pkg::LEAF_VA_ADD &&
     first_operand_register != 64'(epml_pkg::TYPE_VERSION_ARRAY))
    |=> done && result == epml_pkg::RES_GP && err_code == 16'h0000)
    else $error("bad type did not fault");
  chk_rec_align_gp: assert property (
    (cmd_ready && cmd_valid && leaf_selector_register == epml_pkg::LEAF_INFO_RD &&
     s_q.ctrl[epml_pkg::CTRL_INFO_PRESENT] &&
     first_operand_register[epml_pkg::REC_ALIGN_BITS-1:0] != '0)
    |=> done && result == epml_pkg::RES_GP)
    else $error("misaligned record did not fault");
  chk_outside_pf: assert property (
    (add_ack && !meta_in_cache)
    |=> done && result == epml_pkg::RES_PF && fault_addr == $past(s_q.base))
    else $error("outside page not faulted");
  chk_conflict_exit: assert property (
    (add_ack && meta_in_cache && meta_conflict && s_q.ctrl[epml_pkg::CTRL_GUEST] &&
     s_q.ctrl[epml_pkg::CTRL_VIRT_EXT])
    |=> done && result == epml_pkg::RES_EXIT && exit_gpa == $past(meta_phys))
    else $error("conflict did not exit");
  chk_valid_pf: assert property (
    (add_ack && meta_in_cache && !meta_conflict && meta_valid)
    |=> done && result == epml_pkg::RES_PF)
    else $error("valid page not faulted");
  chk_zero_data: assert property (
    (mem_wr_valid && !s_q.info) |-> mem_wr_data == 64'h0 && page_lock)
    else $error("page word not zero");
  chk_meta_after_zero: assert property (
    last_zero_word |=> meta_then_done)
    else $error("metadata write missing");
  chk_meta_fields: assert property (
    meta_wr |-> meta_wr_valid && meta_wr_attr == 7'h00 && meta_wr_location == 64'h0 &&
                meta_wr_type == epml_pkg::TYPE_VERSION_ARRAY)
    else $error("metadata fields wrong");
  chk_flags_kept: assert property (
    (done && !s_q.info) |-> !flags_upd)
    else $error("add reported flags");
  chk_conflict_zf: assert property (
    (s_q.st == S_WAIT && meta_ack && s_q.info && meta_in_cache && meta_conflict)
    |=> done && zf && !cf && ret_code == epml_pkg::RC_CONFLICT && !mem_wr_valid)
    else $error("conflict answer wrong");
endmodule : epml_leaf_unit
`default_nettype wire

// *** verif/epml_leaf_unit_tb.sv ***
// Self-checking bench for the page metadata leaf unit.
// Assumes lookups are answered one cycle after meta_req and the memory port stalls every other cycle.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [63:0] PG = 64'h0000000000045000;
  localparam logic [63:0] REC = 64'h0000000000008040;
  localparam logic [63:0] PHYS = 64'h00000000a0045000;
  localparam logic [63:0] CTX = 64'h1234abcd5678ef01;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, meta_type = 8'h00;
  logic [31:0] reg_wdata = 32'h0, leaf_selector_register = 32'h0;
  logic [63:0] first_operand_register = 64'h0, second_operand_register = 64'h0;
  logic meta_ack = 1'b0, meta_in_cache = 1'b0, meta_conflict = 1'b0, meta_valid = 1'b0;
  logic mem_wr_ready = 1'b0;
  logic [6:0] m_attr = 7'h00;
  logic [31:0] reg_rdata;
  logic irq, cmd_ready, meta_req, meta_wr, meta_wr_valid, page_lock, mem_wr_valid;
  logic done, flags_upd, zf, cf, lock_at_req;
  logic [63:0] meta_addr, meta_wr_location, mem_wr_addr, mem_wr_data, fault_addr;
  logic [63:0] ret_code, exit_gpa;
  logic [7:0] meta_wr_type;
  logic [6:0] meta_wr_attr;
  logic [1:0] result;
  logic [15:0] err_code, exit_reason, exit_qual, exit_error;
  logic [63:0] wa[$];
  logic [63:0] wd[$];
  int fails = 0;
  int n_compared = 0;
  int n_meta = 0;
  int cyc = 0;

  epml_leaf_unit #(.PAGE_WORDS(4)) epml_leaf_unit_i (
    .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .cmd_valid, .cmd_ready, .leaf_selector_register, .first_operand_register,
    .second_operand_register, .meta_req, .meta_addr, .meta_ack, .meta_in_cache,
    .meta_conflict, .meta_valid, .meta_type, .meta_blocked(m_attr[3]),
    .meta_pending(m_attr[4]), .meta_modified(m_attr[5]), .meta_restrict(m_attr[6]),
    .meta_rwx(m_attr[2:0]), .meta_phys(PHYS), .meta_context(CTX), .meta_wr,
    .meta_wr_type, .meta_wr_location, .meta_wr_attr, .meta_wr_valid, .page_lock,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .done, .result,
    .fault_addr, .err_code, .ret_code, .flags_upd, .zf, .cf, .exit_reason,
    .exit_qual, .exit_error, .exit_gpa
  );

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    check($sformatf("reg %h", a), reg_rdata, e);
  endtask : reg_check

  task automatic set_meta(input logic c, input logic f, input logic v, input logic [7:0] t,
                          input logic [6:0] a);
    meta_in_cache <= c;
    meta_conflict <= f;
    meta_valid <= v;
    meta_type <= t;
    m_attr <= a;
  endtask : set_meta

  // Bounded wait on done; results are sampled in the done cycle
  task automatic run_cmd(input logic [31:0] l, input logic [63:0] a, input logic [63:0] b,
                         input logic [1:0] res);
    int k;
    wa.delete();
    wd.delete();
    n_meta = 0;
    leaf_selector_register <= l;
    first_operand_register <= a;
    second_operand_register <= b;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    check("cmd_ready", cmd_ready, 1'b1);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (done !== 1'b1 && k < 500);
    check("done", done, 1'b1);
    check("result", result, res);
  endtask : run_cmd

  task automatic check_wr(input int n, input logic [63:0] base, input logic [63:0] e0,
                          input logic [63:0] e1, input logic [63:0] e2);
    logic [63:0] e[3];
    e = '{e0, e1, e2};
    check("write count", 64'(wa.size()), 64'(n));
    for (int i = 0; i < n && i < wa.size(); i++) begin
      check("write addr", wa[i], base + 64'(8 * i));
      check("write data", wd[i], e[(i > 2) ? 2 : i]);
    end
  endtask : check_wr

  task automatic info_ok(input logic [7:0] t, input logic [6:0] a, input logic [63:0] ctx);
    set_meta(1'b1, 1'b0, 1'b1, t, a);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC, PG, epml_pkg::RES_OK);
    check_wr(3, REC, epml_pkg::STS_VALID, {48'h0, t, 1'b0, a}, ctx);
    check("ret_code", ret_code, epml_pkg::RC_OK);
    check("upd zf cf", {flags_upd, zf, cf}, 3'b100);
  endtask : info_ok

  // ----------------------------------------
  // Far side: lookup answers, stalling memory, metadata writes
  // ----------------------------------------
  always @(posedge mclk) begin
    meta_ack <= meta_req;
    mem_wr_ready <= ~mem_wr_ready;
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      wa.push_back(mem_wr_addr);
      wd.push_back(mem_wr_data);
    end
    if (meta_req === 1'b1) begin
      lock_at_req = page_lock;
      check("meta_addr", meta_addr, second_operand_register);
    end
    if (meta_wr === 1'b1) begin
      n_meta++;
      check("meta_wr_type", meta_wr_type, epml_pkg::TYPE_VERSION_ARRAY);
      check("meta_wr_location", meta_wr_location, 64'h0);
      check("meta_wr attr valid", {meta_wr_attr, meta_wr_valid}, 8'h01);
    end
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reg_check(epml_pkg::ADDR_CTRL, 32'h1);
    reg_check(epml_pkg::ADDR_STATUS, 32'h0);
    reg_write(8'h14, 32'hffffffff);
    reg_check(8'h14, 32'h0);
    reg_write(epml_pkg::ADDR_ENABLE, 32'h2);
    reg_check(epml_pkg::ADDR_ENABLE, 32'h2);
    set_meta(1'b1, 1'b0, 1'b0, epml_pkg::TYPE_CONTROL, 7'h00);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h2, PG, epml_pkg::RES_GP);
    check("err_code", err_code, 16'h0);
    reg_check(epml_pkg::ADDR_CLEAR, 32'h0);
    check("irq", irq, 1'b1);
    reg_write(epml_pkg::ADDR_CLEAR, 32'hf);
    reg_check(epml_pkg::ADDR_STATUS, 32'h0);
    check("irq", irq, 1'b0);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h3, PG + 64'h800, epml_pkg::RES_GP);
    reg_write(epml_pkg::ADDR_ENABLE, 32'h4);
    check("irq masked", irq, 1'b0);
    set_meta(1'b0, 1'b0, 1'b0, epml_pkg::TYPE_CONTROL, 7'h00);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h3, PG, epml_pkg::RES_PF);
    check("fault_addr", fault_addr, PG);
    reg_check(epml_pkg::ADDR_ENABLE, 32'h4);
    check("irq", irq, 1'b1);
    reg_write(epml_pkg::ADDR_CLEAR, 32'hf);
    set_meta(1'b1, 1'b1, 1'b0, epml_pkg::TYPE_CONTROL, 7'h00);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h3, PG, epml_pkg::RES_GP);
    reg_write(epml_pkg::ADDR_CTRL, 32'h3);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h3, PG, epml_pkg::RES_GP);
    reg_write(epml_pkg::ADDR_CTRL, 32'h7);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h3, PG, epml_pkg::RES_EXIT);
    check("exit fields", {exit_reason, exit_qual, exit_error}, {epml_pkg::EXIT_REASON_CONFLICT,
          epml_pkg::EXIT_QUAL_CONFLICT, epml_pkg::EXIT_ERROR});
    check("exit_gpa", exit_gpa, PHYS);
    reg_write(epml_pkg::ADDR_CTRL, 32'h1);
    set_meta(1'b1, 1'b0, 1'b1, epml_pkg::TYPE_REGULAR, 7'h00);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'h3, PG, epml_pkg::RES_PF);
    check("meta writes", 64'(n_meta), 64'h0);
    set_meta(1'b1, 1'b0, 1'b0, epml_pkg::TYPE_CONTROL, 7'h00);
    run_cmd(epml_pkg::LEAF_VA_ADD, 64'(epml_pkg::TYPE_VERSION_ARRAY), PG, epml_pkg::RES_OK);
    check_wr(4, PG, 64'h0, 64'h0, 64'h0);
    check("meta writes", 64'(n_meta), 64'h1);
    check("lock at lookup", lock_at_req, 1'b1);
    check("flags_upd", flags_upd, 1'b0);
    info_ok(epml_pkg::TYPE_REGULAR, 7'h2d, CTX);
    info_ok(epml_pkg::TYPE_VERSION_ARRAY, 7'h52, 64'h0);
    set_meta(1'b0, 1'b0, 1'b0, epml_pkg::TYPE_REGULAR, 7'h00);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC, PG, epml_pkg::RES_OK);
    check_wr(1, REC, epml_pkg::STS_NON_CACHE, 64'h0, 64'h0);
    check("ret_code", ret_code, epml_pkg::RC_NON_CACHE);
    check("upd zf cf", {flags_upd, zf, cf}, 3'b101);
    set_meta(1'b1, 1'b0, 1'b0, epml_pkg::TYPE_REGULAR, 7'h00);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC, PG, epml_pkg::RES_OK);
    check_wr(1, REC, epml_pkg::STS_INVALID, 64'h0, 64'h0);
    check("ret_code", ret_code, epml_pkg::RC_INVALID);
    check("upd zf cf", {flags_upd, zf, cf}, 3'b101);
    set_meta(1'b1, 1'b1, 1'b1, epml_pkg::TYPE_REGULAR, 7'h00);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC, PG, epml_pkg::RES_OK);
    check_wr(0, REC, 64'h0, 64'h0, 64'h0);
    check("ret_code", ret_code, epml_pkg::RC_CONFLICT);
    check("upd zf cf", {flags_upd, zf, cf}, 3'b110);
    reg_check(epml_pkg::ADDR_RESULT, 32'h00000080);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC + 64'h10, PG, epml_pkg::RES_GP);
    check("flags_upd", flags_upd, 1'b0);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC, PG + 64'h40, epml_pkg::RES_GP);
    reg_write(epml_pkg::ADDR_CTRL, 32'h0);
    run_cmd(epml_pkg::LEAF_INFO_RD, REC, PG, epml_pkg::RES_GP);
    run_cmd(32'h0000000b, 64'h3, PG, epml_pkg::RES_GP);
    test_done();
  end
endmodule : testbench
`default_nettype wire
